// [logic/ssp_top.v]
// Purpose: Synchronous serial port with APB registers and FIFOs.
// Assumes: Serial pins are synchronous to ref_clk_i.
// Notes:   Serial mode: clock idles low, data changes on the falling
//          edge and is sampled on the rising edge, MSB first.
// Contract
// - Control bit 2: 0 master, 1 slave; written only while disabled.
// - Control bit 1 enables serial frames; 0 halts serial operation.
// - Control bit 0 loops the transmit shifter into the receive shifter.
// - Data bits 15:0; read pops receive FIFO, write pushes transmit.
// - Transmitter loads one entry into the shifter, shifts at bit rate.
// - Short frames: words right-justified, upper transmit bits ignored.
// - Short frames: received words stored right-justified.
// - Command format sends only the low byte; receive uses data size.
// - Clearing the enable never flushes either FIFO.
// - Status bit 4 is busy: frame active or transmit FIFO not empty.
// - Status bit 3 receive full, bit 2 receive not empty; reset 0.
// - Status bit 1 transmit has space, bit 0 transmit empty; reset 1.
// - Prescale divisor bits 7:0 divide the clock for the bit clock.
// - Divisor bit 0 is hardwired to zero.
// - Interrupt mask is read/write, resets 0, 1 unmasks.
// - Interrupt bit 3 tx at most half full, bit 2 rx at least half.
// - Interrupt bit 1 receive time-out, bit 0 receive overflow.
// - Raw status ignores writes; transmit bit resets 1, others 0.
// - Masked status is raw AND mask, read-only, resets zero.
// - Writing 1 to clear register bits clears time-out or overflow.
`include "ssp_defs.vh"
`timescale 1ns/1ns
module ssp_top #(
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire ref_clk_i,
    input wire reset_n_i,
    input wire [11:0] paddr_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    output reg serial_bit_clock_o,
    output reg serial_bit_clock_oe_o,
    input wire serial_bit_clock_i,
    output reg frame_sel_n_o,
    output reg frame_sel_oe_o,
    input wire frame_sel_n_i,
    output wire serial_out_pin_o,
    output reg serial_out_oe_o,
    input wire serial_in_i,
    output reg irq_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_XFER = 3'b010;
    localparam ST_DONE = 3'b100;
    localparam [AW:0] HALF = DEPTH / 2;

    reg [2:0] ctl_q;
    reg [5:0] cfg_q;
    reg [6:0] pre_q;
    reg [3:0] im_q;
    reg rto_q;
    reg ror_q;
    reg [2:0] state_q;
    reg [15:0] tx_sh_q;
    reg [15:0] rx_sh_q;
    reg [4:0] bit_q;
    reg last_q;
    reg [6:0] div_q;
    reg [6:0] rto_cnt_q;
    reg sclk_prev_q;
    reg fss_prev_q;
    reg [31:0] rd_mux;
    reg tx_pop;
    reg rx_push;

    wire setup = psel_i & ~penable_i;
    wire done = psel_i & penable_i & pready_o;
    wire wr = done & pwrite_i;
    wire rd = done & ~pwrite_i;
    wire hit = (paddr_i[1:0] == 2'b00) & (paddr_i <= `SSP_OFF_ICR);
    wire en = ctl_q[`SSP_CTL_EN];
    wire master = ~ctl_q[`SSP_CTL_MS];
    wire cmd_fmt = (cfg_q[`SSP_CFG_FMT_HI:`SSP_CFG_FMT_LO] == `SSP_FMT_CMD);
    wire [15:0] tx_head;
    wire [15:0] rx_head;
    wire [AW:0] tx_cnt;
    wire [AW:0] rx_cnt;
    wire tx_full;
    wire tx_empty;
    wire rx_full;
    wire rx_empty;
    wire [4:0] size_bits;
    wire [4:0] skip_bits;
    wire [4:0] total_bits;
    wire tick;
    wire rise;
    wire fall;
    wire rx_in;
    wire [3:0] raw;
    wire tx_push = wr & (paddr_i == `SSP_OFF_DATA);
    wire rx_pop = rd & (paddr_i == `SSP_OFF_DATA);
    wire busy = ~state_q[0] | ~tx_empty;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Frame width from the size code; reserved codes act as 4 bits
    function [4:0] ssp_bits;
        input [3:0] code;
        begin
            if (code < `SSP_MIN_SIZE_CODE) begin
                ssp_bits = {1'b0, `SSP_MIN_SIZE_CODE} + 5'h01;
            end else begin
                ssp_bits = {1'b0, code} + 5'h01;
            end
        end
    endfunction

    // Moves the low len bits to the top; the unused upper bits drop out
    function [15:0] ssp_align;
        input [15:0] word;
        input [4:0] len;
        begin
            ssp_align = word << (`SSP_WORD_BITS - len);
        end
    endfunction

    // ------------------------------------------------------------
    // FIFOs
    // ------------------------------------------------------------
    // Eight by sixteen each; enable never touches them
    ssp_fifo #(.WIDTH(16), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
        .clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .push_i(tx_push),
        .wdata_i(pwdata_i[15:0]),
        .pop_i(tx_pop),
        .rdata_o(tx_head),
        .count_o(tx_cnt),
        .full_o(tx_full),
        .empty_o(tx_empty)
    );

    ssp_fifo #(.WIDTH(16), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
        .clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .push_i(rx_push),
        .wdata_i(rx_sh_q),
        .pop_i(rx_pop),
        .rdata_o(rx_head),
        .count_o(rx_cnt),
        .full_o(rx_full),
        .empty_o(rx_empty)
    );

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    assign raw = {tx_cnt <= HALF, rx_cnt >= HALF, rto_q, ror_q};

    // Register read view, reserved bits zero
    always @* begin
        rd_mux = 32'h0000_0000;
        case (paddr_i)
            `SSP_OFF_CFG: rd_mux[5:0] = cfg_q;
            `SSP_OFF_CTL: rd_mux[2:0] = ctl_q;
            `SSP_OFF_DATA: rd_mux[15:0] = rx_head;
            `SSP_OFF_STAT: rd_mux[4:0] = {busy, rx_full, ~rx_empty,
                ~tx_full, tx_empty};
            `SSP_OFF_PRE: rd_mux[7:0] = {pre_q, 1'b0};
            `SSP_OFF_IM: rd_mux[3:0] = im_q;
            `SSP_OFF_RIS: rd_mux[3:0] = raw;
            `SSP_OFF_MIS: rd_mux[3:0] = raw & im_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Zero wait states: data and ready are set up during setup phase
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= setup;
            pslverr_o <= setup & ~hit;
            if (setup) begin
                prdata_o <= rd_mux;
            end else begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    // Control, config, prescale and mask writes
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            ctl_q <= `SSP_CTL_RST;
            cfg_q <= `SSP_CFG_RST;
            pre_q <= `SSP_PRE_RST;
            im_q <= `SSP_IM_RST;
        end else if (wr) begin
            case (paddr_i)
                `SSP_OFF_CFG: cfg_q <= pwdata_i[5:0];
                `SSP_OFF_CTL: begin
                    ctl_q[`SSP_CTL_EN] <= pwdata_i[`SSP_CTL_EN];
                    ctl_q[`SSP_CTL_LB] <= pwdata_i[`SSP_CTL_LB];
                    if (!en) begin
                        ctl_q[`SSP_CTL_MS] <= pwdata_i[`SSP_CTL_MS];
                    end
                end
                `SSP_OFF_PRE: pre_q <= pwdata_i[7:1];
                `SSP_OFF_IM: im_q <= pwdata_i[3:0];
                default: ctl_q <= ctl_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bit rate
    // ------------------------------------------------------------
    // Half-period tick every divisor/2 clocks; bit rate is clk/divisor
    assign tick = ({1'b0, div_q} + 8'h01 >= {1'b0, pre_q});

    always @(posedge ref_clk_i) begin
        if (!reset_n_i || tick) begin
            div_q <= 7'h00;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

    // Edges come from our own clock as master, from the pin as slave
    assign rise = master ? (tick & ~serial_bit_clock_o)
        : (serial_bit_clock_i & ~sclk_prev_q);
    assign fall = master ? (tick & serial_bit_clock_o)
        : (~serial_bit_clock_i & sclk_prev_q);
    assign rx_in = ctl_q[`SSP_CTL_LB] ? tx_sh_q[15] : serial_in_i;
    assign serial_out_pin_o = tx_sh_q[15];

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    assign size_bits = ssp_bits(cfg_q[`SSP_CFG_SIZE_HI:0]);
    assign skip_bits = cmd_fmt ? `SSP_CMD_BITS : 5'h00;
    assign total_bits = skip_bits + size_bits;

    // Pop and push strobes decided by the engine state
    always @* begin
        tx_pop = 1'b0;
        rx_push = state_q[2];
        if (state_q[0] && en) begin
            if (master) begin
                tx_pop = ~tx_empty;
            end else begin
                tx_pop = fss_prev_q & ~frame_sel_n_i & ~tx_empty;
            end
        end
    end

    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            tx_sh_q <= 16'h0000;
            rx_sh_q <= 16'h0000;
            bit_q <= 5'h00;
            last_q <= 1'b0;
            serial_bit_clock_o <= 1'b0;
            frame_sel_n_o <= 1'b1;
            sclk_prev_q <= 1'b0;
            fss_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= serial_bit_clock_i;
            fss_prev_q <= frame_sel_n_i;
            case (state_q)
                ST_IDLE: begin
                    tx_sh_q <= 16'h0000;
                    bit_q <= 5'h00;
                    last_q <= 1'b0;
                    serial_bit_clock_o <= 1'b0;
                    frame_sel_n_o <= 1'b1;
                    if (en && (tx_pop || (!master && fss_prev_q
                            && !frame_sel_n_i))) begin
                        // Command format sends the low byte only
                        tx_sh_q <= cmd_fmt
                            ? ssp_align(tx_head, `SSP_CMD_BITS)
                            : ssp_align(tx_head, size_bits);
                        if (!tx_pop) begin
                            tx_sh_q <= 16'h0000;
                        end
                        rx_sh_q <= 16'h0000;
                        frame_sel_n_o <= ~master;
                        state_q <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (master && tick) begin
                        serial_bit_clock_o <= ~serial_bit_clock_o;
                    end
                    if (rise) begin
                        if (bit_q >= skip_bits) begin
                            rx_sh_q <= {rx_sh_q[14:0], rx_in};
                        end
                        bit_q <= bit_q + 5'h01;
                        if (bit_q + 5'h01 == total_bits) begin
                            last_q <= 1'b1;
                            if (!master) begin
                                state_q <= ST_DONE;
                            end
                        end
                    end
                    if (fall) begin
                        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
                        if (master && last_q) begin
                            state_q <= ST_DONE;
                        end
                    end
                    // Disable or dropped select abandons the frame
                    if (!en || (!master && frame_sel_n_i)) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_DONE: begin
                    frame_sel_n_o <= 1'b1;
                    serial_bit_clock_o <= 1'b0;
                    tx_sh_q <= 16'h0000;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Pin drivers: clock and select only as master, data as master or selected slave, all while enabled
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            serial_bit_clock_oe_o <= 1'b0;
            frame_sel_oe_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end else begin
            serial_bit_clock_oe_o <= en & master;
            frame_sel_oe_o <= en & master;
            serial_out_oe_o <= en & (master | ~frame_sel_n_i);
        end
    end

    // ------------------------------------------------------------
    // Interrupt conditions
    // ------------------------------------------------------------
    // Sticky time-out and overflow; a new event beats a clear
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rto_q <= 1'b0;
            ror_q <= 1'b0;
            rto_cnt_q <= 7'h00;
            irq_o <= 1'b0;
        end else begin
            if (wr && paddr_i == `SSP_OFF_ICR) begin
                if (pwdata_i[`SSP_IRQ_RT]) begin
                    rto_q <= 1'b0;
                end
                if (pwdata_i[`SSP_IRQ_ROR]) begin
                    ror_q <= 1'b0;
                end
            end
            if (rx_push && rx_full) begin
                ror_q <= 1'b1;
            end
            // Idle with unread data for a fixed number of ticks
            if (rx_empty || rx_push || rx_pop || !state_q[0]) begin
                rto_cnt_q <= 7'h00;
            end else if (tick && rto_cnt_q != `SSP_RTO_TICKS) begin
                rto_cnt_q <= rto_cnt_q + 7'h01;
                if (rto_cnt_q + 7'h01 == `SSP_RTO_TICKS) begin
                    rto_q <= 1'b1;
                end
            end
            irq_o <= |(raw & im_q);
        end
    end

endmodule

// [include/ssp_defs.vh]
// Purpose: Register map, field positions and timing counts of the
//          synchronous serial port.
// Assumes: APB byte addresses, 32-bit words.
// Notes:   Definitions only.
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SSP_AW 12
`define SSP_OFF_CFG 12'h000
`define SSP_OFF_CTL 12'h004
`define SSP_OFF_DATA 12'h008
`define SSP_OFF_STAT 12'h00C
`define SSP_OFF_PRE 12'h010
`define SSP_OFF_IM 12'h014
`define SSP_OFF_RIS 12'h018
`define SSP_OFF_MIS 12'h01C
`define SSP_OFF_ICR 12'h020

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define SSP_CTL_LB 0
`define SSP_CTL_EN 1
`define SSP_CTL_MS 2
`define SSP_CFG_SIZE_HI 3
`define SSP_CFG_FMT_HI 5
`define SSP_CFG_FMT_LO 4
`define SSP_FMT_CMD 2'h2
`define SSP_IRQ_TX 3
`define SSP_IRQ_RX 2
`define SSP_IRQ_RT 1
`define SSP_IRQ_ROR 0

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define SSP_WORD_BITS 5'h10
`define SSP_CMD_BITS 5'h08
`define SSP_MIN_SIZE_CODE 4'h3
`define SSP_CTL_RST 3'h0
`define SSP_CFG_RST 6'h00
`define SSP_PRE_RST 7'h00
`define SSP_IM_RST 4'h0
`define SSP_RTO_TICKS 7'h40

`endif

// [logic/ssp_fifo.v]
// Purpose: Small synchronous FIFO with a registered head word.
// Assumes: Push when full and pop when empty are ignored.
// Notes:   rdata_o always holds the oldest entry.
`timescale 1ns/1ns
module ssp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire push_i,
    input wire [WIDTH-1:0] wdata_i,
    input wire pop_i,
    output reg [WIDTH-1:0] rdata_o,
    output wire [AW:0] count_o,
    output wire full_o,
    output wire empty_o
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire do_push;
    wire do_pop;
    wire [AW-1:0] rd_ptr_d;

    assign full_o = (count_q == DEPTH[AW:0]);
    assign empty_o = (count_q == {(AW+1){1'b0}});
    assign count_o = count_q;
    assign do_push = push_i & ~full_o;
    assign do_pop = pop_i & ~empty_o;
    assign rd_ptr_d = do_pop ? rd_ptr_q + 1'b1 : rd_ptr_q;

    // Storage and pointers; head is refetched with write bypass
    always @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr_q] <= wdata_i;
        end
        if (!reset_n_i) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
            rdata_o <= {WIDTH{1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_q + {{AW{1'b0}}, do_push}
                - {{AW{1'b0}}, do_pop};
            if (do_push && (wr_ptr_q == rd_ptr_d)) begin
                rdata_o <= wdata_i;
            end else begin
                rdata_o <= mem[rd_ptr_d];
            end
        end
    end

endmodule

// [bench/ssp_checker.sv]
// Purpose: Port-level checks of the serial port register block.
// Assumes: Zero-wait APB answers, master bit clock idles low.
// Notes:   Bound onto ssp_top from the bench top file.
`include "ssp_defs.vh"
`timescale 1ns/1ns
module ssp_checker (
    input wire ref_clk_i,
    input wire reset_n_i,
    input wire [11:0] paddr_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire serial_bit_clock_o,
    input wire serial_bit_clock_oe_o,
    input wire frame_sel_n_o,
    input wire frame_sel_oe_o,
    input wire irq_o
);
    logic [3:0] mask_q;
    // -------------------------------------------------------------
    // Shadow of the interrupt mask, taken from completed writes
    // -------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            mask_q <= 4'h0;
        end else if (psel_i && penable_i && pready_o && pwrite_i &&
                     paddr_i == `SSP_OFF_IM) begin
            mask_q <= pwdata_i[3:0];
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Setup phase and a completed read of one offset
    sequence apb_setup;
        psel_i && !penable_i;
    endsequence
    sequence rd_hit(off);
        psel_i && penable_i && pready_o && !pwrite_i && paddr_i == off;
    endsequence
    chk_ready_follows: assert property (
        apb_setup |=> pready_o ##1 !pready_o)
        else $error("ready did not pulse once after setup");
    chk_pre_lsb: assert property (
        rd_hit(`SSP_OFF_PRE) |-> prdata_o[0] == 1'b0)
        else $error("prescale bit 0 read back set");
    chk_mask_readback: assert property (
        rd_hit(`SSP_OFF_IM) |-> prdata_o[3:0] == mask_q)
        else $error("mask read differs from last write");
    chk_busy_tx: assert property (
        rd_hit(`SSP_OFF_STAT) |-> prdata_o[4] || prdata_o[0])
        else $error("tx not empty but busy clear");
    chk_rx_flags: assert property (
        rd_hit(`SSP_OFF_STAT) |-> !(prdata_o[3] && !prdata_o[2]))
        else $error("rx full while rx empty");
    chk_tx_flags: assert property (
        rd_hit(`SSP_OFF_STAT) |-> prdata_o[1] || !prdata_o[0])
        else $error("tx empty while tx full");
    chk_mis_gated: assert property (
        rd_hit(`SSP_OFF_MIS) |-> (prdata_o[3:0] & ~mask_q) == 4'h0)
        else $error("masked status shows a masked bit");
    chk_irq_masked: assert property (
        mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq_o)
        else $error("interrupt high with all masked");
    chk_clock_framed: assert property (
        serial_bit_clock_o |-> !frame_sel_n_o && serial_bit_clock_oe_o)
        else $error("bit clock high outside a frame");
    chk_sel_driven: assert property (
        !frame_sel_n_o |-> frame_sel_oe_o)
        else $error("frame select low but not driven");
endmodule

// [bench/ssp_partner.sv]
// Purpose: Far-side serial slave fed by the port's master pins.
// Assumes: Clock idles low, sample on rise, change on fall, MSB first.
// Notes:   Sends PATTERN each frame; records what it received.
`timescale 1ns/1ns
module ssp_partner #(
    parameter [15:0] PATTERN = 16'hc3a5
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire bit_clk_i,
    input wire sel_n_i,
    input wire data_i,
    output wire data_o,
    output logic [15:0] seen_o
);
    logic clk_q, sel_q, toggle_q;
    logic [15:0] shift_q;
    // Outside a frame the line wanders so no stale bit looks valid
    assign data_o = sel_n_i ? toggle_q : shift_q[15];
    // Reload while deselected, capture on rise, shift on fall
    always @(posedge clk_i) begin
        clk_q <= bit_clk_i;
        sel_q <= sel_n_i;
        toggle_q <= ~toggle_q;
        if (!reset_n_i) begin
            toggle_q <= 1'b0;
            shift_q <= PATTERN;
            seen_o <= 16'h0000;
        end else if (sel_n_i) begin
            shift_q <= PATTERN;
        end else if (sel_q) begin
            seen_o <= 16'h0000;
        end else if (!clk_q && bit_clk_i) begin
            seen_o <= {seen_o[14:0], data_i};
        end else if (clk_q && !bit_clk_i) begin
            shift_q <= {shift_q[14:0], ~shift_q[15]};
        end
    end
endmodule

// [bench/sync_serial_regs_fifo_bench.sv]
// Purpose: Self-checking bench of the serial port register block.
// Assumes: Master role, prescale 8, partner slave on the pins.
// Notes:   Random words from a fixed seed; loopback fills the FIFOs.
`include "ssp_defs.vh"
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) \
    begin failures++; $display("[ERR] t=%0t got=%h exp=%h", $time, \
    got, exp); end end
module sync_serial_regs_fifo_bench;
    localparam [15:0] PAT = 16'hc3a5;
    logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic err, fss_in = 1;
    logic [15:0] w, words [0:7];
    wire [31:0] prdata;
    wire [15:0] seen;
    wire pready, pslverr, bclk, bclk_oe, fss_n, fss_oe, sout, sout_oe;
    wire sin, irq;
    integer failures = 0, samples_checked = 0, cycles = 0, seed = 62, i, n;
    always #4 ref_clk = ~ref_clk;
    ssp_top dut (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .serial_bit_clock_o(bclk), .serial_bit_clock_oe_o(bclk_oe),
        .serial_bit_clock_i(1'b0), .frame_sel_n_o(fss_n),
        .frame_sel_oe_o(fss_oe), .frame_sel_n_i(fss_in),
        .serial_out_pin_o(sout), .serial_out_oe_o(sout_oe),
        .serial_in_i(sin), .irq_o(irq));
    ssp_partner #(.PATTERN(PAT)) peer (.clk_i(ref_clk),
        .reset_n_i(reset_n), .bit_clk_i(bclk), .sel_n_i(fss_n),
        .data_i(sout), .data_o(sin), .seen_o(seen));
    // -------------------------------------------------------------
    // Bus tasks and helpers
    // -------------------------------------------------------------
    task automatic apb(input logic we, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= we;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask
    // Poll status until the busy flag drops
    task automatic wait_idle;
        do begin
            apb(1'b0, `SSP_OFF_STAT, 32'h0000_0000);
        end while (rd[4] !== 1'b0);
    endtask
    function automatic [15:0] low_mask(input integer len);
        low_mask = 16'hffff >> (16 - len);
    endfunction
    task automatic complete_run;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Cut a hung run short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            complete_run;
        end
    end
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rdchk(`SSP_OFF_STAT, 32'h0000_0003);
        rdchk(`SSP_OFF_RIS, 32'h0000_0008);
        rdchk(`SSP_OFF_IM, 32'h0000_0000);
        rdchk(`SSP_OFF_MIS, 32'h0000_0000);
        rdchk(`SSP_OFF_CTL, 32'h0000_0000);
        $display("test reset_values done");
        w = $random(seed);
        wr(`SSP_OFF_IM, {28'h0, w[3:0]});
        rdchk(`SSP_OFF_IM, {28'h0, w[3:0]});
        `CHK(irq, w[3])
        wr(`SSP_OFF_RIS, 32'hffff_ffff);
        rdchk(`SSP_OFF_RIS, 32'h0000_0008);
        wr(`SSP_OFF_MIS, 32'hffff_ffff);
        rdchk(`SSP_OFF_MIS, {28'h0, w[3:0] & 4'h8});
        wr(`SSP_OFF_PRE, {24'h0, w[15:8] | 8'h01});
        rdchk(`SSP_OFF_PRE, {24'h0, w[15:9], 1'b0});
        apb(1'b0, 12'h024, 32'h0000_0000);
        `CHK(err, 1'b1)
        wr(`SSP_OFF_IM, 32'h0000_0000);
        $display("test registers done");
        wr(`SSP_OFF_PRE, 32'h0000_0008);
        for (i = 0; i < 5; i++) begin
            n = 4 + ({$random(seed)} % 13);
            w = $random(seed);
            wr(`SSP_OFF_CTL, 32'h0000_0000);
            wr(`SSP_OFF_CFG, (i == 4) ? 32'h0000_0027 : n - 1);
            wr(`SSP_OFF_DATA, {16'h0, w});
            wr(`SSP_OFF_CTL, 32'h0000_0002);
            wait_idle;
            if (i == 4) begin
                `CHK(seen[15:8], w[7:0])
                rdchk(`SSP_OFF_DATA, {24'h0, PAT[7:0]});
            end else begin
                `CHK(seen & low_mask(n), w & low_mask(n))
                rdchk(`SSP_OFF_DATA, {16'h0, PAT >> (16 - n)});
            end
        end
        wr(`SSP_OFF_CTL, 32'h0000_0000);
        wr(`SSP_OFF_CTL, 32'h0000_0006);
        fss_in <= 1'b0;
        rdchk(`SSP_OFF_CTL, 32'h0000_0006);
        rdchk(`SSP_OFF_STAT, 32'h0000_0013);
        `CHK({bclk_oe, sout_oe}, 2'b01)
        fss_in <= 1'b1;
        $display("test master_frames done");
        wr(`SSP_OFF_CTL, 32'h0000_0000);
        wr(`SSP_OFF_CFG, 32'h0000_000f);
        for (i = 0; i < 8; i++) begin
            words[i] = $random(seed);
            wr(`SSP_OFF_DATA, {16'h0, words[i]});
        end
        wr(`SSP_OFF_DATA, 32'h0000_1234);
        rdchk(`SSP_OFF_STAT, 32'h0000_0010);
        rdchk(`SSP_OFF_RIS, 32'h0000_0000);
        wr(`SSP_OFF_CTL, 32'h0000_0001);
        rdchk(`SSP_OFF_STAT, 32'h0000_0010);
        wr(`SSP_OFF_CTL, 32'h0000_0003);
        wr(`SSP_OFF_CTL, 32'h0000_0007);
        rdchk(`SSP_OFF_CTL, 32'h0000_0003);
        wait_idle;
        rdchk(`SSP_OFF_STAT, 32'h0000_000f);
        apb(1'b0, `SSP_OFF_RIS, 32'h0000_0000);
        `CHK(rd & 32'h0000_000d, 32'h0000_000c)
        wr(`SSP_OFF_DATA, 32'h0000_00aa);
        wait_idle;
        wr(`SSP_OFF_IM, 32'h0000_0001);
        rdchk(`SSP_OFF_MIS, 32'h0000_0001);
        `CHK(irq, 1'b1)
        wr(`SSP_OFF_ICR, 32'h0000_0000);
        rdchk(`SSP_OFF_MIS, 32'h0000_0001);
        wr(`SSP_OFF_ICR, 32'h0000_0001);
        rdchk(`SSP_OFF_MIS, 32'h0000_0000);
        `CHK(irq, 1'b0)
        wr(`SSP_OFF_IM, 32'h0000_0002);
        repeat (300) @(posedge ref_clk);
        rdchk(`SSP_OFF_MIS, 32'h0000_0002);
        for (i = 0; i < 8; i++) begin
            rdchk(`SSP_OFF_DATA, {16'h0, words[i]});
        end
        rdchk(`SSP_OFF_STAT, 32'h0000_0003);
        wr(`SSP_OFF_ICR, 32'h0000_0003);
        rdchk(`SSP_OFF_RIS, 32'h0000_0008);
        $display("test loopback_fifo done");
        complete_run;
    end
endmodule
bind ssp_top ssp_checker chk (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o),
    .serial_bit_clock_o(serial_bit_clock_o),
    .serial_bit_clock_oe_o(serial_bit_clock_oe_o),
    .frame_sel_n_o(frame_sel_n_o), .frame_sel_oe_o(frame_sel_oe_o),
    .irq_o(irq_o));
